// ### hdl/flash_erase_defines.vh
`ifndef FLASH_ERASE_DEFINES_VH
`define FLASH_ERASE_DEFINES_VH
// Software register map of the controller (word index on the command port).
`define REG_CTRL 4'h0
`define REG_SECTOR 4'h1
`define REG_STATUS 4'h2
`define REG_POLL 4'h3
// Control register fields.
`define CTRL_CHIP 0
`define CTRL_SECTOR 1
`define CTRL_SUSPEND 2
`define CTRL_RESUME 3
`define CTRL_RESET 4
`define CTRL_ADDSEC 5
// Status register fields.
`define ST_BUSY 0
`define ST_SUSP 1
`define ST_FAIL 2
`define ST_DONE 3
`define ST_TMO 4
// Command words and unlock addresses.
`define ADR_UNLOCK1 12'h555
`define ADR_UNLOCK2 12'h2aa
`define DAT_UNLOCK1 8'haa
`define DAT_UNLOCK2 8'h55
`define DAT_SETUP 8'h80
`define DAT_CHIP 8'h10
`define DAT_SECTOR 8'h30
`define DAT_SUSPEND 8'hb0
`define DAT_RESUME 8'h30
`define DAT_RESET 8'hf0
// Write pulse timing at 40 MHz: the write-enable low phase and the hold phase of a bus write each last this many cycles.
`define WR_PHASE_NS 50
`define CLK_NS 25
`define WR_PHASE_CYC ((`WR_PHASE_NS + `CLK_NS - 1) / `CLK_NS)
// Gap kept below the sector acceptance window: 50 us minus margin, rounded down.
`define SEC_GAP_US 40
`define SEC_GAP_CYC ((`SEC_GAP_US * 1000) / `CLK_NS)
`define RESET_LOW_NS 500
`define RESET_LOW_CYC ((`RESET_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### hdl/flash_bus_writer.v
`timescale 1ns/10ps
`include "flash_erase_defines.vh"
// Performs one asynchronous flash write cycle: address and data set up, write enable low, then high.
module flash_bus_writer (
    input wire clk_sys,
    input wire rstn,
    input wire start,
    input wire [19:0] addr,
    input wire [7:0] data,
    output reg busy_q,
    output reg weN_q,
    output reg ceN_q,
    output reg [19:0] addrOut_q,
    output reg [7:0] dataOut_q,
    output reg dataOe_q
);
    localparam S_IDLE = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_LOW = 2'd2;
    localparam S_HOLD = 2'd3;
    localparam [31:0] PHASE_LAST = `WR_PHASE_CYC - 1;
    reg [1:0] state_q;
    reg [3:0] cnt_q;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            weN_q <= 1'b1;
            ceN_q <= 1'b1;
            addrOut_q <= 20'h00000;
            dataOut_q <= 8'h00;
            dataOe_q <= 1'b1;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        addrOut_q <= addr;
                        dataOut_q <= data;
                        dataOe_q <= 1'b0;
                        ceN_q <= 1'b0;
                        busy_q <= 1'b1;
                        cnt_q <= 4'h0;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    weN_q <= 1'b0;
                    cnt_q <= 4'h0;
                    state_q <= S_LOW;
                end
                S_LOW: begin
                    if (cnt_q == PHASE_LAST[3:0]) begin
                        weN_q <= 1'b1;
                        cnt_q <= 4'h0;
                        state_q <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: begin
                    if (cnt_q == PHASE_LAST[3:0]) begin
                        ceN_q <= 1'b1;
                        dataOe_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
            endcase
        end
    end
endmodule

// ### hdl/flash_erase_command_sequencer.v
`timescale 1ns/10ps
`include "flash_erase_defines.vh"
// Summary of operation
// - Chip erase: six writes, two unlocks, set-up, two unlocks, chip erase command.
// - Hardware reset aborts erase; reissue the whole sequence afterwards.
// - Sector erase: six writes ending with sector address plus sector erase command.
// - Controller keeps gaps between extra sector writes below 50 us.
// - Any other command in the window aborts; the sequence must be rewritten.
// - Resume with any address continues; repeated resume ignored; suspend allowed again.
// - If data bit 5 rises during erase, write the reset command.
module flash_erase_command_sequencer (
    input wire clk_sys,
    input wire rstn,
    input wire [3:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata_q,
    output reg [19:0] flashAddr_q,
    output reg [7:0] flashDataOut_q,
    output reg flashDataOeN_q,
    input wire [7:0] flashDataIn,
    output reg flashWeN_q,
    output reg flashCeN_q,
    output reg flashOeN_q,
    output reg flashResetN_q,
    input wire ready_busy_n_output
);
    localparam S_IDLE = 4'd0;
    localparam S_SEQ = 4'd1;
    localparam S_WAIT = 4'd2;
    localparam S_READ = 4'd3;
    localparam S_CHECK = 4'd4;
    localparam S_WINDOW = 4'd5;
    localparam S_HWRST = 4'd6;
    localparam S_SUSP = 4'd7;
    localparam [31:0] GAP_LIMIT = `SEC_GAP_CYC;
    localparam [31:0] RESET_HOLD = `RESET_LOW_CYC;

    reg [3:0] state_q;
    reg [2:0] step_q;
    reg isChip_q;
    reg [4:0] sector_q;
    reg [4:0] pendSector_q;
    reg pendAdd_q;
    reg pendSusp_q;
    reg pendResume_q;
    reg suspSent_q;
    reg suspended_q;
    reg busy_q;
    reg fail_q;
    reg done_q;
    reg timedOut_q;
    reg [7:0] poll_q;
    reg [15:0] timer_q;
    reg [1:0] rdCnt_q;
    reg [1:0] rbSync_q;
    reg [7:0] dqSync1_q;
    reg [7:0] dqSync2_q;
    reg start_q;
    reg [19:0] wAddr_q;
    reg [7:0] wData_q;
    wire wBusy;
    wire wWeN;
    wire wCeN;
    wire [19:0] wAddrOut;
    wire [7:0] wDataOut;
    wire wOeN;

    flash_bus_writer u_writer (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(start_q),
        .addr(wAddr_q),
        .data(wData_q),
        .busy_q(wBusy),
        .weN_q(wWeN),
        .ceN_q(wCeN),
        .addrOut_q(wAddrOut),
        .dataOut_q(wDataOut),
        .dataOe_q(wOeN)
    );

    // Pins from the flash are asynchronous to clk_sys.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rbSync_q <= 2'b11;
            dqSync1_q <= 8'h00;
            dqSync2_q <= 8'h00;
        end else begin
            rbSync_q <= {rbSync_q[0], ready_busy_n_output};
            dqSync1_q <= flashDataIn;
            dqSync2_q <= dqSync1_q;
        end
    end

    wire ctrlWr = regWr && (regAddr == `REG_CTRL);
    // An add-sector word carries the sector number in the low bits, so it must not also act as a command.
    wire addSec = ctrlWr && regWdata[`CTRL_ADDSEC];
    wire ctrlCmd = ctrlWr && !regWdata[`CTRL_ADDSEC];
    wire busFree = !wBusy && !start_q;

    // Address and data of each of the six erase cycles.
    reg [19:0] seqAddr;
    reg [7:0] seqData;
    always @* begin
        seqAddr = {8'h00, `ADR_UNLOCK1};
        seqData = `DAT_UNLOCK1;
        case (step_q)
            3'd1, 3'd4: begin
                seqAddr = {8'h00, `ADR_UNLOCK2};
                seqData = `DAT_UNLOCK2;
            end
            3'd2: seqData = `DAT_SETUP;
            3'd5: begin
                if (isChip_q) begin
                    seqData = `DAT_CHIP;
                end else begin
                    seqAddr = {sector_q, 15'h0000};
                    seqData = `DAT_SECTOR;
                end
            end
            default: seqData = `DAT_UNLOCK1;
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            step_q <= 3'd0;
            isChip_q <= 1'b0;
            sector_q <= 5'h00;
            pendSector_q <= 5'h00;
            pendAdd_q <= 1'b0;
            pendSusp_q <= 1'b0;
            pendResume_q <= 1'b0;
            suspSent_q <= 1'b0;
            suspended_q <= 1'b0;
            busy_q <= 1'b0;
            fail_q <= 1'b0;
            done_q <= 1'b0;
            timedOut_q <= 1'b0;
            poll_q <= 8'h00;
            timer_q <= 16'h0000;
            rdCnt_q <= 2'd0;
            start_q <= 1'b0;
            wAddr_q <= 20'h00000;
            wData_q <= 8'h00;
            flashOeN_q <= 1'b1;
            flashResetN_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
            if (addSec) begin
                pendAdd_q <= 1'b1;
                pendSector_q <= regWdata[4:0];
            end
            if (ctrlCmd && regWdata[`CTRL_SUSPEND] && busy_q && !isChip_q) begin
                pendSusp_q <= 1'b1;
            end
            if (ctrlCmd && regWdata[`CTRL_RESUME] && suspended_q) begin
                pendResume_q <= 1'b1;
            end
            if (regWr && regAddr == `REG_SECTOR) begin
                sector_q <= regWdata[4:0];
            end
            if (ctrlCmd && regWdata[`CTRL_RESET] && busy_q) begin
                flashResetN_q <= 1'b0;
                // An abort in mid-poll must not leave the output enable stuck low.
                flashOeN_q <= 1'b1;
                timer_q <= 16'h0000;
                state_q <= S_HWRST;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (ctrlCmd && (regWdata[`CTRL_CHIP] || regWdata[`CTRL_SECTOR])) begin
                            isChip_q <= regWdata[`CTRL_CHIP];
                            busy_q <= 1'b1;
                            done_q <= 1'b0;
                            fail_q <= 1'b0;
                            timedOut_q <= 1'b0;
                            pendSusp_q <= 1'b0;
                            suspSent_q <= 1'b0;
                            pendAdd_q <= 1'b0;
                            step_q <= 3'd0;
                            state_q <= S_SEQ;
                        end else if (suspended_q && pendResume_q && busFree) begin
                            wAddr_q <= 20'h00000;
                            wData_q <= `DAT_RESUME;
                            start_q <= 1'b1;
                            pendResume_q <= 1'b0;
                            suspended_q <= 1'b0;
                            busy_q <= 1'b1;
                            state_q <= S_WAIT;
                        end
                    end
                    S_SEQ: begin
                        if (busFree) begin
                            wAddr_q <= seqAddr;
                            wData_q <= seqData;
                            start_q <= 1'b1;
                            if (step_q == 3'd5) begin
                                timer_q <= 16'h0000;
                                state_q <= isChip_q ? S_WAIT : S_WINDOW;
                            end
                            step_q <= step_q + 3'd1;
                        end
                    end
                    S_WINDOW: begin
                        // Extra sectors go out well inside the acceptance window.
                        timer_q <= timer_q + 16'h0001;
                        if (pendSusp_q && busFree) begin
                            wAddr_q <= 20'h00000;
                            wData_q <= `DAT_SUSPEND;
                            start_q <= 1'b1;
                            suspSent_q <= 1'b1;
                            state_q <= S_WAIT;
                        end else if (pendAdd_q && busFree && timer_q < GAP_LIMIT[15:0]) begin
                            wAddr_q <= {pendSector_q, 15'h0000};
                            wData_q <= `DAT_SECTOR;
                            start_q <= 1'b1;
                            pendAdd_q <= addSec;
                            timer_q <= 16'h0000;
                        end else if (busFree && timer_q >= GAP_LIMIT[15:0]) begin
                            pendAdd_q <= 1'b0;
                            state_q <= S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        if (busFree) begin
                            flashOeN_q <= 1'b0;
                            rdCnt_q <= 2'd0;
                            state_q <= S_READ;
                        end
                    end
                    S_READ: begin
                        rdCnt_q <= rdCnt_q + 2'd1;
                        if (rdCnt_q == 2'd3) begin
                            poll_q <= dqSync2_q;
                            flashOeN_q <= 1'b1;
                            state_q <= S_CHECK;
                        end
                    end
                    default: begin
                        if (state_q == S_CHECK) begin
                            timedOut_q <= poll_q[3];
                            // An erasing sector reads bit 7 low, a suspended one reads it high.
                            if (pendSusp_q && rbSync_q[1] && poll_q[7]) begin
                                suspended_q <= 1'b1;
                                pendSusp_q <= 1'b0;
                                suspSent_q <= 1'b0;
                                busy_q <= 1'b0;
                                state_q <= S_IDLE;
                            end else if (pendSusp_q && !suspSent_q && busFree && poll_q[3]) begin
                                // Sent once only: a repeated suspend would restart the flash's suspend delay.
                                wAddr_q <= 20'h00000;
                                wData_q <= `DAT_SUSPEND;
                                start_q <= 1'b1;
                                suspSent_q <= 1'b1;
                                state_q <= S_WAIT;
                            end else if (poll_q[5] && !poll_q[7] && busFree) begin
                                wAddr_q <= 20'h00000;
                                wData_q <= `DAT_RESET;
                                start_q <= 1'b1;
                                fail_q <= 1'b1;
                                busy_q <= 1'b0;
                                state_q <= S_IDLE;
                            end else if (rbSync_q[1] && poll_q[7]) begin
                                busy_q <= 1'b0;
                                done_q <= 1'b1;
                                state_q <= S_IDLE;
                            end else begin
                                state_q <= S_WAIT;
                            end
                        end else begin
                            timer_q <= timer_q + 16'h0001;
                            if (timer_q == RESET_HOLD[15:0]) begin
                                flashResetN_q <= 1'b1;
                                busy_q <= 1'b0;
                                suspended_q <= 1'b0;
                                state_q <= S_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flashAddr_q <= 20'h00000;
            flashDataOut_q <= 8'h00;
            flashDataOeN_q <= 1'b1;
            flashWeN_q <= 1'b1;
            flashCeN_q <= 1'b1;
            regRdata_q <= 32'h00000000;
        end else begin
            flashAddr_q <= wAddrOut;
            flashDataOut_q <= wDataOut;
            flashDataOeN_q <= wOeN;
            flashWeN_q <= wWeN;
            flashCeN_q <= wCeN && flashOeN_q;
            if (regRd) begin
                if (regAddr == `REG_STATUS) begin
                    regRdata_q <= {27'h0000000, timedOut_q, done_q, fail_q, suspended_q, busy_q};
                end else if (regAddr == `REG_POLL) begin
                    regRdata_q <= {24'h000000, poll_q};
                end else if (regAddr == `REG_SECTOR) begin
                    regRdata_q <= {27'h0000000, sector_q};
                end else begin
                    regRdata_q <= 32'h00000000;
                end
            end else begin
                regRdata_q <= 32'h00000000;
            end
        end
    end
endmodule

// ### test/flash_erase_checker_properties.sv
`timescale 1ns/10ps
module flash_erase_checker (
    input wire clk_sys,
    input wire rstn,
    input wire regRd,
    input wire [31:0] regRdata_q,
    input wire [19:0] flashAddr_q,
    input wire [7:0] flashDataOut_q,
    input wire flashDataOeN_q,
    input wire flashWeN_q,
    input wire flashCeN_q,
    input wire flashOeN_q,
    input wire flashResetN_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence weLowTwo;
        !flashWeN_q ##1 !flashWeN_q ##1 flashWeN_q;
    endsequence
    sequence resetLow;
        !flashResetN_q [*8];
    endsequence
    AST_WE_PULSE:
    assert property ($fell(flashWeN_q) |-> weLowTwo) else $error("write pulse length wrong");
    AST_CE_LEADS:
    assert property ($fell(flashWeN_q) |-> !$past(flashCeN_q)) else $error("chip enable late");
    AST_LATCH_EDGE:
    assert property ($rose(flashWeN_q) |-> !flashCeN_q && $stable(flashDataOut_q)) else $error("latch edge bad");
    AST_WRITE_BUS:
    assert property (!flashWeN_q |-> !flashDataOeN_q && flashOeN_q && flashResetN_q) else $error("bus not driven");
    AST_BUS_STABLE:
    assert property (!flashWeN_q && !$past(flashWeN_q) |-> $stable(flashAddr_q)) else $error("address moved");
    AST_UNLOCK_ONE:
    assert property ($rose(flashWeN_q) && flashDataOut_q == 8'haa |-> flashAddr_q[11:0] == 12'h555)
        else $error("first unlock address wrong");
    AST_UNLOCK_TWO:
    assert property ($rose(flashWeN_q) && flashDataOut_q == 8'h55 |-> flashAddr_q[11:0] == 12'h2aa)
        else $error("second unlock address wrong");
    AST_SETUP_ADDR:
    assert property ($rose(flashWeN_q) && flashDataOut_q inside {8'h80, 8'h10} |-> flashAddr_q[11:0] == 12'h555)
        else $error("set-up address wrong");
    AST_RESET_PULSE:
    assert property ($fell(flashResetN_q) |-> resetLow) else $error("reset pulse short");
    AST_READ_RELEASE:
    assert property (!flashOeN_q |-> flashDataOeN_q && flashWeN_q) else $error("read while driving");
    AST_RDATA_IDLE:
    assert property (!$past(regRd) |-> regRdata_q == 32'h0) else $error("read data not idle");
endmodule
bind flash_erase_command_sequencer flash_erase_checker u_chk (.clk_sys, .rstn, .regRd, .regRdata_q, .flashAddr_q,
    .flashDataOut_q, .flashDataOeN_q, .flashWeN_q, .flashCeN_q, .flashOeN_q, .flashResetN_q);

// ### test/flash_erase_model.sv
`timescale 1ns/10ps
module flash_erase_model #(
    parameter ERASE_CYC = 1500,
    parameter WIN_CYC = 2000,
    parameter SUSP_CYC = 400
) (
    input wire clk_sys,
    input wire [19:0] flashAddr_q,
    input wire [7:0] flashDataOut_q,
    input wire flashWeN_q,
    input wire flashCeN_q,
    input wire flashOeN_q,
    input wire flashResetN_q,
    input wire failInj,
    output wire [7:0] flashDataIn,
    output wire ready_busy_n_output,
    output logic [2:0] mode,
    output logic [31:0] mask,
    output logic bad
);
    logic [2:0] st;
    logic [31:0] tmr, wt, sp;
    logic pw, po, tgl;
    logic [7:0] lastQ, stv;
    wire [7:0] d = flashDataOut_q;
    wire [31:0] bit1 = 32'h1 << flashAddr_q[19:15];
    wire [11:0] wantA = (st == 3'd1 || st == 3'd4) ? 12'h2aa : 12'h555;
    wire [7:0] wantD = (st == 3'd2) ? 8'h80 : (st == 3'd1 || st == 3'd4) ? 8'h55 : 8'haa;
    initial begin
        {mode, mask, bad, st, tmr, wt, sp, tgl, lastQ} = '0;
        {pw, po} = 2'b11;
    end
    always @* begin
        case (mode)
            3'd0: stv = 8'hff;
            3'd4: stv = bit1 & mask ? {1'b1, 4'h0, tgl, 2'h0} : 8'hff;
            default: stv = {1'b0, tgl, failInj, 1'b0, mode != 3'd2, tgl, 2'h0};
        endcase
    end
    // A released bus shows the inverse of the last byte so a stale read cannot pass.
    assign flashDataIn = (!flashOeN_q && !flashCeN_q) ? stv : ~lastQ;
    assign ready_busy_n_output = !(mode == 3'd1 || mode == 3'd2 || mode == 3'd3);
    always @(posedge clk_sys or negedge flashResetN_q) begin
        if (!flashResetN_q) begin
            {mode, st, sp, mask} <= '0;
        end else begin
            pw <= flashWeN_q;
            po <= flashOeN_q;
            if (flashOeN_q && !po) tgl <= ~tgl;
            if (!flashOeN_q && !flashCeN_q) lastQ <= flashDataIn;
            if (mode == 3'd1 || mode == 3'd3) begin
                tmr <= tmr + 1;
                if (tmr == ERASE_CYC) {mode, mask} <= '0;
            end
            if (mode == 3'd2) begin
                wt <= wt + 1;
                if (wt == WIN_CYC) {mode, tmr} <= {3'd3, 32'h0};
            end
            if (sp != 0) sp <= (sp == SUSP_CYC) ? 0 : sp + 1;
            if (sp == SUSP_CYC && mode == 3'd3) mode <= 3'd4;
            if (flashWeN_q && !pw && !flashCeN_q) begin
                case (mode)
                    3'd0: if (d == 8'hf0) st <= 0;
                        else if (st < 5 && flashAddr_q[11:0] == wantA && d == wantD) st <= st + 1;
                        else if (st == 5 && flashAddr_q[11:0] == 12'h555 && d == 8'h10) begin
                            {mode, tmr, st} <= {3'd1, 32'h0, 3'd0};
                        end else if (st == 5 && d == 8'h30) begin
                            {mode, wt, st, mask} <= {3'd2, 32'h0, 3'd0, bit1};
                        end else {bad, st} <= 4'h8;
                    3'd2: if (d == 8'h30) {mask, wt} <= {mask | bit1, 32'h0};
                        else if (d == 8'hb0) mode <= 3'd4;
                        else {mode, mask} <= '0;
                    3'd4: if (d == 8'h30) {mode, tmr} <= {3'd3, tmr[31:6], 6'h0};
                    default: if (failInj && d == 8'hf0) {mode, mask} <= '0;
                        else if (mode == 3'd3 && d == 8'hb0) sp <= 1;
                endcase
            end
        end
    end
endmodule

// ### test/flash_erase_command_sequencer_bench.sv
`timescale 1ns/10ps
module flash_erase_command_sequencer_bench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic failInj = 1'b0;
    wire [31:0] regRdata_q, mask;
    wire [19:0] flashAddr_q;
    wire [7:0] flashDataOut_q, flashDataIn;
    wire flashDataOeN_q, flashWeN_q, flashCeN_q, flashOeN_q, flashResetN_q, ready_busy_n_output, bad;
    wire [2:0] mode;
    integer error_cnt = 0;
    integer comparisons = 0;
    integer i, k;
    logic [31:0] s, expMask;
    logic [15:0] rnd = 16'h2a7a;
    always #12.5 clk_sys = ~clk_sys;
    flash_erase_command_sequencer u_dut (.clk_sys, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata_q,
        .flashAddr_q, .flashDataOut_q, .flashDataOeN_q, .flashDataIn, .flashWeN_q, .flashCeN_q, .flashOeN_q,
        .flashResetN_q, .ready_busy_n_output);
    flash_erase_model u_flash (.clk_sys, .flashAddr_q, .flashDataOut_q, .flashWeN_q, .flashCeN_q, .flashOeN_q,
        .flashResetN_q, .failInj, .flashDataIn, .ready_busy_n_output, .mode, .mask, .bad);
    function [15:0] lfsr(input [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task chk(input string n, input [31:0] seen, input [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task wr(input [3:0] a, input [31:0] dat);
        @(posedge clk_sys);
        {regAddr, regWdata, regWr} <= {a, dat, 1'b1};
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge clk_sys);
        {regAddr, regRd} <= {a, 1'b1};
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 s = regRdata_q;
    endtask
    task waitst(input [31:0] m, input [31:0] v);
        for (i = 0; i < 6000; i++) begin
            rd(4'h2);
            if ((s & m) === v) break;
        end
    endtask
    task waitm(input [2:0] m);
        for (i = 0; i < 8000 && mode !== m; i++) @(posedge clk_sys);
    endtask
    task sector_start;
        rnd = lfsr(rnd);
        expMask = 32'h1 << rnd[4:0];
        wr(4'h1, {27'h0, rnd[4:0]});
        wr(4'h0, 32'h2);
        waitm(3'd2);
    endtask
    task close_out;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        $display("watchdog expired");
        close_out;
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(4'hf);
        chk("unmapped", s, 32'h0);
        rd(4'h2);
        chk("idle status", s, 32'h0);
        wr(4'h0, 32'h1);
        waitm(3'd1);
        chk("chip mode", mode, 3'd1);
        waitst(1, 1);
        chk("busy", s[0], 1'b1);
        wr(4'h0, 32'h4);
        repeat (60) @(posedge clk_sys);
        chk("suspend in chip", mode, 3'd1);
        waitst(8, 8);
        chk("chip done", s[3:0], 4'h8);
        chk("array read", mode, 3'd0);
        sector_start;
        for (k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            expMask = expMask | (32'h1 << rnd[4:0]);
            wr(4'h0, {26'h0, 1'b1, rnd[4:0]});
            // The controller holds one pending sector; let each go out before the next.
            repeat (16) @(posedge clk_sys);
        end
        waitm(3'd3);
        chk("sector set", mask, expMask);
        waitst(16, 16);
        chk("window expired", s[4], 1'b1);
        wr(4'h0, 32'h4);
        waitst(2, 2);
        chk("suspended", s[1], 1'b1);
        chk("suspend mode", mode, 3'd4);
        wr(4'h0, 32'h8);
        wr(4'h0, 32'h8);
        waitst(2, 0);
        waitm(3'd3);
        chk("resumed", mode, 3'd3);
        waitst(8, 8);
        chk("sector done", s[3:0], 4'h8);
        sector_start;
        wr(4'h0, 32'h4);
        waitst(2, 2);
        chk("window suspend", mode, 3'd4);
        wr(4'h0, 32'h8);
        waitst(8, 8);
        chk("resume done", s[3:0], 4'h8);
        sector_start;
        waitm(3'd3);
        @(posedge clk_sys);
        failInj <= 1'b1;
        waitst(4, 4);
        chk("fail flag", s[2], 1'b1);
        waitm(3'd0);
        chk("fail reset", mode, 3'd0);
        @(posedge clk_sys);
        failInj <= 1'b0;
        wr(4'h0, 32'h1);
        waitm(3'd1);
        wr(4'h0, 32'h10);
        waitm(3'd0);
        chk("hard reset", mode, 3'd0);
        chk("sequence", bad, 1'b0);
        close_out;
    end
endmodule
